// file: include/topc_cfg.svh
// offsets, field positions, reset values and protocol codes for the trace output config block
`ifndef TOPC_CFG_SVH
`define TOPC_CFG_SVH

// register byte offsets
`define TOPC_OFF_DIVIDER     8'h10
`define TOPC_OFF_PROTOCOL    8'hf0
`define TOPC_OFF_CAPABILITY  8'hfc

// field positions
`define TOPC_DIV_MSB         15
`define TOPC_PROT_MSB        1
`define TOPC_CAP_NRZ_BIT     11
`define TOPC_CAP_MANC_BIT    10
`define TOPC_CAP_PARA_BIT    9
`define TOPC_CAP_FIFO_MSB    8
`define TOPC_CAP_FIFO_LSB    6

// reset values
`define TOPC_RST_DIVIDER     16'h0000
`define TOPC_RST_PROTOCOL    2'h0

// protocol codes
`define TOPC_PROT_PARALLEL   2'h0
`define TOPC_PROT_MANCHESTER 2'h1
`define TOPC_PROT_NRZ        2'h2

`endif

// file: include/topc_pkg.sv
// types shared by the trace output config block
`default_nettype none

package topc_pkg;

   typedef enum logic [1:0] {
      TOPC_PARALLEL,
      TOPC_MANCHESTER,
      TOPC_NRZ,
      TOPC_RESERVED
   } topc_proto_e;

   // register bus request
   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } topc_req_s;

   // single-wire clock status
   typedef struct packed {
      logic        tick;
      logic [15:0] count;
   } topc_tick_s;

endpackage : topc_pkg

`default_nettype wire

// file: logic/topc_divider.sv
// prescale counter producing the single-wire bit clock tick
`timescale 1ns/1ps
`default_nettype none
`include "topc_cfg.svh"

module topc_divider #(
   parameter int unsigned DIV_W = 16
) (
   input  wire logic                 clock,
   input  wire logic                 nrst,
   input  wire logic                 reload,
   input  wire logic     [DIV_W-1:0] divider,
   output var  topc_pkg::topc_tick_s tick_o
);

   logic [DIV_W-1:0] count_ff;
   logic [DIV_W-1:0] nxt_count;
   logic             tick_ff;
   logic             at_end;

   // counts down from the divider, tick on reaching zero: period = divider + 1
   assign at_end    = (count_ff == '0);
   assign nxt_count = (reload || at_end) ? divider : count_ff - 1'b1;

   // reload on write so a new baud rate starts at once
   always_ff @(posedge clock)
   begin
      if (!nrst)
      begin
         count_ff <= '0;
         tick_ff  <= 1'b0;
      end
      else
      begin
         count_ff <= nxt_count;
         tick_ff  <= at_end && !reload;
      end
   end

   assign tick_o.tick  = tick_ff;
   assign tick_o.count = 16'(count_ff);

endmodule : topc_divider
`default_nettype wire

// file: logic/topc_output_config.sv
// register file and baud prescaler for the trace output protocol configuration
`timescale 1ns/1ps
`default_nettype none
`include "topc_cfg.svh"

module topc_output_config #(
   parameter int unsigned DIV_W        = 16,
   parameter bit          HAS_NRZ      = 1'b1,
   parameter bit          HAS_MANC     = 1'b1,
   parameter bit          HAS_PARALLEL = 1'b1,
   parameter logic [2:0]  FIFO_LOG2    = 3'h3
) (
   input  wire logic                    clock,
   input  wire logic                    nrst,
   input  wire logic [7:0]              addr,
   input  wire logic [31:0]             wdata,
   input  wire logic                    wr,
   input  wire logic                    rd,
   output logic      [31:0]             rdata,
   output logic                         bit_clock_tick,
   output var topc_pkg::topc_proto_e    output_protocol_select,
   output logic      [15:0]             output_baud_divider
);

   ////////////////////////////////////////////////////////////////////////////
   // decode

   localparam bit SERIAL = HAS_NRZ || HAS_MANC;

   topc_pkg::topc_req_s req;
   assign req.addr  = addr;
   assign req.wdata = wdata;
   assign req.wr    = wr;
   assign req.rd    = rd;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction : hit

   wire sel_div  = hit(req.addr, `TOPC_OFF_DIVIDER);
   wire sel_prot = hit(req.addr, `TOPC_OFF_PROTOCOL);
   wire sel_cap  = hit(req.addr, `TOPC_OFF_CAPABILITY);

   wire wr_div  = req.wr && sel_div && SERIAL;
   wire wr_prot = req.wr && sel_prot;

   ////////////////////////////////////////////////////////////////////////////
   // registers

   logic [15:0]           div_ff;
   logic [1:0]            prot_ff;
   logic [31:0]           rdata_ff;
   topc_pkg::topc_proto_e prot_out_ff;
   logic [15:0]           div_out_ff;
   logic                  tick_ff;
   logic [15:0]           nxt_div;
   logic [1:0]            nxt_prot;

   // keep only implemented divider bits, rest read zero
   wire [15:0] div_mask = 16'(({DIV_W{1'b1}}));
   assign nxt_div  = wr_div ? (req.wdata[`TOPC_DIV_MSB:0] & div_mask) : div_ff;
   // two-bit field, writes to 31:2 dropped
   assign nxt_prot = wr_prot ? req.wdata[`TOPC_PROT_MSB:0] : prot_ff;

   // capability word assembled from build parameters
   wire [31:0] cap_word;
   assign cap_word[`TOPC_CAP_NRZ_BIT]  = HAS_NRZ;
   assign cap_word[`TOPC_CAP_MANC_BIT] = HAS_MANC;
   // inverted sense: one means no parallel port
   assign cap_word[`TOPC_CAP_PARA_BIT] = !HAS_PARALLEL;
   // FIFO size as log2 of bytes
   assign cap_word[`TOPC_CAP_FIFO_MSB:`TOPC_CAP_FIFO_LSB] = FIFO_LOG2;
   // reserved and implementation bits read zero
   assign cap_word[31:12] = 20'h00000;
   assign cap_word[5:0]   = 6'h00;

   // read mux, unmapped addresses return zero
   wire [31:0] rd_mux = sel_div  ? {16'h0000, (SERIAL ? div_ff : 16'h0000)} :
                        sel_prot ? {30'h00000000, prot_ff} :
                        sel_cap  ? cap_word : 32'h00000000;

   // one-cycle read latency; data held only for the cycle after the strobe
   always_ff @(posedge clock)
   begin
      if (!nrst)
      begin
         div_ff   <= `TOPC_RST_DIVIDER;
         prot_ff  <= `TOPC_RST_PROTOCOL;
         rdata_ff <= 32'h00000000;
      end
      else
      begin
         div_ff   <= nxt_div;
         prot_ff  <= nxt_prot;
         rdata_ff <= req.rd ? rd_mux : 32'h00000000;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // prescaler

   topc_pkg::topc_tick_s tick_s;

   // write strobe reloads the counter the same edge
   topc_divider #(
      .DIV_W (16)
   ) u_div (
      .clock   (clock),
      .nrst    (nrst),
      .reload  (wr_div),
      .divider (nxt_div),
      .tick_o  (tick_s)
   );

   // protocol code drives the output mode selector
   always_ff @(posedge clock)
   begin
      if (!nrst)
      begin
         prot_out_ff <= topc_pkg::TOPC_PARALLEL;
         div_out_ff  <= 16'h0000;
         tick_ff     <= 1'b0;
      end
      else
      begin
         case (nxt_prot)
            `TOPC_PROT_PARALLEL:   prot_out_ff <= topc_pkg::TOPC_PARALLEL;
            `TOPC_PROT_MANCHESTER: prot_out_ff <= topc_pkg::TOPC_MANCHESTER;
            `TOPC_PROT_NRZ:        prot_out_ff <= topc_pkg::TOPC_NRZ;
            default:               prot_out_ff <= topc_pkg::TOPC_RESERVED; // unusable code
         endcase
         div_out_ff <= nxt_div;
         // tick only used by the serial encoders
         tick_ff    <= tick_s.tick && (prot_ff != `TOPC_PROT_PARALLEL);
      end
   end

   assign rdata                  = rdata_ff;
   assign output_protocol_select = prot_out_ff;
   assign output_baud_divider    = div_out_ff;
   assign bit_clock_tick         = tick_ff;

   ////////////////////////////////////////////////////////////////////////////
   // checks

   // cycles since last counter tick, and divider untouched since
   logic [15:0] gap_ff;
   logic        clean_ff;
   logic [15:0] nxt_gap;
   logic        nxt_clean;
   assign nxt_gap   = tick_s.tick ? 16'h0000 : gap_ff + 16'h0001;
   assign nxt_clean = tick_s.tick ? !wr_div : (clean_ff && !wr_div);

   // check helper only; any divider write voids the measurement until the next tick
   always_ff @(posedge clock)
   begin
      if (!nrst)
      begin
         gap_ff   <= 16'h0000;
         clean_ff <= 1'b0;
      end
      else
      begin
         gap_ff   <= nxt_gap;
         clean_ff <= nxt_clean;
      end
   end

   // undisturbed ticks divider plus one apart
   property p_period;
      @(posedge clock) disable iff (!nrst)
      (tick_s.tick && clean_ff) |-> gap_ff == div_ff;
   endproperty
   a_period: assert property (p_period) else $error("bit clock period wrong");

   property p_prot_store;
      @(posedge clock) disable iff (!nrst)
      wr_prot |=> prot_ff == $past(req.wdata[1:0]);
   endproperty
   a_prot_store: assert property (p_prot_store) else $error("protocol not stored");

   sequence s_prot_wr;
      wr_prot && req.wdata[1:0] == 2'h1;
   endsequence
   property p_mode;
      @(posedge clock) disable iff (!nrst)
      s_prot_wr |=> output_protocol_select == topc_pkg::TOPC_MANCHESTER;
   endproperty
   a_mode: assert property (p_mode) else $error("mode select wrong");

   property p_cap;
      @(posedge clock) disable iff (!nrst)
      (req.rd && sel_cap) |=> rdata[11:9] == {HAS_NRZ, HAS_MANC, !HAS_PARALLEL};
   endproperty
   a_cap: assert property (p_cap) else $error("capability bits wrong");

   property p_fifo;
      @(posedge clock) disable iff (!nrst)
      (req.rd && sel_cap) |=> rdata[8:6] == FIFO_LOG2;
   endproperty
   a_fifo: assert property (p_fifo) else $error("fifo size wrong");

   property p_reload;
      @(posedge clock) disable iff (!nrst)
      wr_div |=> tick_s.count == $past(nxt_div);
   endproperty
   a_reload: assert property (p_reload) else $error("counter not reloaded");

   property p_div_rd;
      @(posedge clock) disable iff (!nrst)
      (req.rd && sel_div) |=> rdata[31:16] == 16'h0000;
   endproperty
   a_div_rd: assert property (p_div_rd) else $error("divider upper bits set");

   property p_rsv;
      @(posedge clock) disable iff (!nrst)
      (req.rd && sel_prot) |=> rdata[31:2] == 30'h00000000;
   endproperty
   a_rsv: assert property (p_rsv) else $error("reserved bits nonzero");

   sequence s_par_wr;
      wr_prot && req.wdata[1:0] == 2'h0;
   endsequence
   property p_mode_par;
      @(posedge clock) disable iff (!nrst)
      s_par_wr |=> output_protocol_select == topc_pkg::TOPC_PARALLEL;
   endproperty
   a_mode_par: assert property (p_mode_par) else $error("parallel select wrong");

   sequence s_nrz_wr;
      wr_prot && req.wdata[1:0] == 2'h2;
   endsequence
   property p_mode_nrz;
      @(posedge clock) disable iff (!nrst)
      s_nrz_wr |=> output_protocol_select == topc_pkg::TOPC_NRZ;
   endproperty
   a_mode_nrz: assert property (p_mode_nrz) else $error("nrz select wrong");

   property p_par_quiet;
      @(posedge clock) disable iff (!nrst)
      (prot_ff == `TOPC_PROT_PARALLEL) |=> !bit_clock_tick;
   endproperty
   a_par_quiet: assert property (p_par_quiet) else $error("tick in parallel mode");

   property p_tick_pass;
      @(posedge clock) disable iff (!nrst)
      (tick_s.tick && prot_ff != `TOPC_PROT_PARALLEL) |=> bit_clock_tick;
   endproperty
   a_tick_pass: assert property (p_tick_pass) else $error("serial tick lost");

   // a capability read, answered the next cycle
   sequence s_cap_rd;
      req.rd && sel_cap;
   endsequence

   property p_cap_nrz;
      @(posedge clock) disable iff (!nrst)
      s_cap_rd |=> rdata[`TOPC_CAP_NRZ_BIT] == HAS_NRZ;
   endproperty
   a_cap_nrz: assert property (p_cap_nrz) else $error("nrz flag wrong");

   property p_cap_manc;
      @(posedge clock) disable iff (!nrst)
      s_cap_rd |=> rdata[`TOPC_CAP_MANC_BIT] == HAS_MANC;
   endproperty
   a_cap_manc: assert property (p_cap_manc) else $error("manchester flag wrong");

   property p_cap_para;
      @(posedge clock) disable iff (!nrst)
      s_cap_rd |=> rdata[`TOPC_CAP_PARA_BIT] == !HAS_PARALLEL;
   endproperty
   a_cap_para: assert property (p_cap_para) else $error("parallel flag wrong");

   property p_cap_rsv;
      @(posedge clock) disable iff (!nrst)
      s_cap_rd |=> rdata[31:12] == 20'h00000 && rdata[5:0] == 6'h00;
   endproperty
   a_cap_rsv: assert property (p_cap_rsv) else $error("capability reserved bits set");

   property p_div_val;
      @(posedge clock) disable iff (!nrst)
      (req.rd && sel_div) |=> rdata[15:0] == $past(div_ff);
   endproperty
   a_div_val: assert property (p_div_val) else $error("divider read wrong");

   property p_div_out;
      @(posedge clock) disable iff (!nrst)
      wr_div |=> output_baud_divider == $past(req.wdata[15:0] & div_mask);
   endproperty
   a_div_out: assert property (p_div_out) else $error("divider output wrong");

endmodule : topc_output_config
`default_nettype wire

// file: tb/topc_probe.sv
// far-side capture probe model measuring bit periods
`timescale 1ns/1ps
`default_nettype none

module topc_probe (
   input  wire logic        clock,
   input  wire logic        nrst,
   input  wire logic        tick,
   output logic      [15:0] period_ff
);
   logic [15:0] cnt_ff;

   always_ff @(posedge clock)
   begin
      cnt_ff <= (!nrst || tick) ? 16'h0001 : cnt_ff + 16'h0001;
      period_ff <= !nrst ? 16'h0000 : (tick ? cnt_ff : period_ff);
   end
endmodule : topc_probe

`default_nettype wire

// file: tb/tb_trace_output_protocol_config.sv
// self-checking bench for the trace output config block
`timescale 1ns/1ps
`default_nettype none
`include "topc_cfg.svh"

module tb_trace_output_protocol_config;
   logic                  clock = 1'b0;
   logic                  nrst = 1'b0;
   logic [7:0]            addr = 8'h00;
   logic [31:0]           wdata = 32'h00000000;
   logic                  wr = 1'b0;
   logic                  rd = 1'b0;
   logic [31:0]           rdata;
   logic                  tick;
   topc_pkg::topc_proto_e prot;
   logic [15:0]           divo;
   logic [15:0]           period_ff;
   logic [31:0]           rv;
   int                    miscompares = 0;
   int                    samples_checked = 0;
   int                    n;

   always #4 clock = ~clock;

   topc_output_config dut (.clock(clock), .nrst(nrst), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .bit_clock_tick(tick),
      .output_protocol_select(prot), .output_baud_divider(divo));
   topc_probe probe (.clock(clock), .nrst(nrst), .tick(tick), .period_ff(period_ff));

   ////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic report_and_stop;
      $display("checked %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : report_and_stop

   // one-cycle strobes, changed right after an edge
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clock);
      wr <= 1'b0;
   endtask : wr_reg

   // data taken in the one cycle after the strobe
   task automatic rd_reg(input logic [7:0] a);
      @(posedge clock);
      rd <= 1'b1;
      addr <= a;
      @(posedge clock);
      rd <= 1'b0;
      #1;
      rv = rdata;
   endtask : rd_reg

   // bounded wait, overrun ends the run
   task automatic wait_tick(input int lim);
      n = 0;
      do
      begin
         @(posedge clock);
         #1;
         n++;
      end
      while (tick !== 1'b1 && n < lim);
      if (tick !== 1'b1)
      begin
         miscompares++;
         report_and_stop();
      end
   endtask : wait_tick

   ////////////////////////////////////////
   task automatic t_regs;
      rd_reg(`TOPC_OFF_DIVIDER);
      check(rv, 32'h00000000);
      rd_reg(`TOPC_OFF_CAPABILITY);
      check(rv, 32'h00000cc0);
      @(posedge clock);
      #1;
      check(rdata, 32'h00000000);
      wr_reg(`TOPC_OFF_DIVIDER, 32'habcd0005);
      #1;
      check({16'h0000, divo}, 32'h00000005);
      rd_reg(`TOPC_OFF_DIVIDER);
      check(rv, 32'h00000005);
      wr_reg(`TOPC_OFF_CAPABILITY, 32'h00000000);
      rd_reg(`TOPC_OFF_CAPABILITY);
      check(rv, 32'h00000cc0);
      rd_reg(8'h20);
      check(rv, 32'h00000000);
      $display("done registers");
   endtask : t_regs

   task automatic t_protocol;
      for (int c = 0; c < 3; c++)
      begin
         wr_reg(`TOPC_OFF_PROTOCOL, 32'hfffffffc | c);
         rd_reg(`TOPC_OFF_PROTOCOL);
         check(rv, c);
         check({30'h0, prot}, c);
      end
      $display("done protocol");
   endtask : t_protocol

   task automatic t_rate;
      wr_reg(`TOPC_OFF_DIVIDER, 32'h000000c8);
      repeat (10) @(posedge clock);
      wr_reg(`TOPC_OFF_DIVIDER, 32'h00000003);
      wait_tick(6);
      check(n, 32'h00000005);
      wait_tick(8);
      check(n, 32'h00000004);
      @(posedge clock);
      #1;
      check({16'h0000, period_ff}, 32'h00000004);
      wr_reg(`TOPC_OFF_PROTOCOL, 32'h00000000);
      repeat (2) @(posedge clock);
      repeat (12)
      begin
         @(posedge clock);
         #1;
         check({31'h0, tick}, 32'h00000000);
      end
      $display("done rate");
   endtask : t_rate

   ////////////////////////////////////////
   initial
   begin
      repeat (8) @(posedge clock);
      nrst <= 1'b1;
      t_regs();
      t_protocol();
      t_rate();
      report_and_stop();
   end
endmodule : tb_trace_output_protocol_config

`default_nettype wire
